/* logic/asc_defs.svh */
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// Clock period, ns
`define ASC_CLK_NS 10
// Minimum times of the fastest grade, ns; asc_ctrl scales them for slower grades
`define ASC_T_CYCLE_NS 15
`define ASC_T_ACCESS_NS 15
`define ASC_T_WPULSE_NS 12
`define ASC_T_WPULSE_GHI_NS 10
`define ASC_T_ADDR_END_NS 12
`define ASC_T_DATA_END_NS 7
`define ASC_T_SEL_END_NS 10
`define ASC_T_OFF_NS 8
// Flops between the data pins and the logic that reads them
`define ASC_SYNC_STAGES 2
// Round a minimum up to whole cycles, at least one
`define ASC_CYC(ns) ((((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS) < 1 ? 1 : \
  (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS))
`define ASC_AW 15
`define ASC_DW 9
`define ASC_CW 4
`define ASC_CNT_ZERO 4'h0
`define ASC_CNT_ONE 4'h1
`define ASC_ADDR_RST 15'h0000
`define ASC_DATA_RST 9'h000

`endif

/* logic/asc_pkg.sv */
package asc_pkg;
  typedef enum logic [4:0] {
    ASC_IDLE = 5'h01,
    ASC_RSETUP = 5'h02,
    ASC_RWAIT = 5'h04,
    ASC_WPULSE = 5'h08,
    ASC_RECOVER = 5'h10
  } asc_state_t;
endpackage : asc_pkg

/* logic/asc_sync.sv */
`timescale 1ns/1ns
`include "asc_defs.svh"
module asc_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pin side and synchronised side
  input wire logic [`ASC_DW-1:0] pinIn,
  output logic [`ASC_DW-1:0] syncOut
);
  logic [`ASC_DW-1:0] meta_q;
  genvar i;
  // Each line gets its own two-flop chain
  generate
    for (i = 0; i < `ASC_DW; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_q[i] <= pinIn[i];
          syncOut[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : asc_sync

/* logic/asc_ctrl.sv */
`timescale 1ns/1ns
`include "asc_defs.svh"
// Rules that this block and the memory it drives work to
// R1: Memory stores data only during select asserted and strobe low overlap.
// R2: Select active needs low select low and high select high together.
// R3: Write strobe stays high through every read cycle.
// R4: Each cycle lasts at least the grade's cycle time between address changes.
// R5: Address valid no later than select edge; data valid within access time.
// R6: Memory holds old data at least 4 ns after an address change.
// R7: Memory drives data within 8 ns of output enable falling.
// R8: Memory floats data within 8 ns of select deasserting.
// R9: Memory starts driving no sooner than 4 ns after select asserts.
// R10: Memory floats data within 7 ns of output enable rising.
// R11: Memory turn-off always faster than turn-on, so no bus contention.
// R12: Strobe low at least 12 ns, or 10 ns with output enable high.
// R13: Address valid 12 ns before write end; zero setup and hold allowed.
// R14: Write data valid 7 ns before write end; zero hold allowed.
// R15: Memory floats within 7 ns of strobe fall, drives 4 ns after rise.
// R16: Enable falling with or after strobe keeps outputs floating.
// R17: Output enable high during write keeps memory outputs floating.
// R18: Select ending at or before strobe rise keeps outputs floating.
// R19: Select asserted at least 10 ns before a select-ended write ends.
// R20: Fifteen address lines, nine shared bidirectional data lines.
// R21: Timing minima become whole clock cycles, rounded up, from grade parameter.
module asc_ctrl #(
  parameter int GRADE_NS = 15
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [`ASC_AW-1:0] reqAddr,
  input wire logic [`ASC_DW-1:0] reqWdata,
  output logic reqReady,
  output logic rspValid,
  output logic [`ASC_DW-1:0] rspRdata,
  // Memory pins
  output logic [`ASC_AW-1:0] address_lines,
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic outEnable_n,
  output logic writeStrobe_n,
  input wire logic [`ASC_DW-1:0] data_lines_i,
  output logic [`ASC_DW-1:0] data_lines_o,
  output logic data_lines_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts; slower grades scale every minimum with the cycle time
  localparam int T_CYC = `ASC_T_CYCLE_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  localparam int T_ACC = `ASC_T_ACCESS_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  localparam int T_WP = `ASC_T_WPULSE_GHI_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  localparam int T_AE = `ASC_T_ADDR_END_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  localparam int T_DE = `ASC_T_DATA_END_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  localparam int T_OFF = `ASC_T_OFF_NS * GRADE_NS / `ASC_T_CYCLE_NS;
  // Read waits access plus two sync flops; write pulse covers all write minima
  localparam int C_RD0 = `ASC_CYC(T_ACC) + `ASC_SYNC_STAGES; // R21
  localparam int C_RD = C_RD0 > `ASC_CYC(T_CYC) ? C_RD0 : `ASC_CYC(T_CYC); // R4
  localparam int C_W1 = `ASC_CYC(T_WP) > `ASC_CYC(T_AE) ? `ASC_CYC(T_WP) : `ASC_CYC(T_AE);
  localparam int C_W2 = C_W1 > `ASC_CYC(T_DE) ? C_W1 : `ASC_CYC(T_DE);
  localparam int C_WR = C_W2 > `ASC_CYC(T_CYC) ? C_W2 : `ASC_CYC(T_CYC); // R4
  localparam int C_OFF = `ASC_CYC(T_OFF);
  localparam logic [`ASC_CW-1:0] RD_CNT = C_RD[`ASC_CW-1:0];
  localparam logic [`ASC_CW-1:0] WR_CNT = C_WR[`ASC_CW-1:0];
  localparam logic [`ASC_CW-1:0] OFF_CNT = C_OFF[`ASC_CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  asc_pkg::asc_state_t state_q, state_d;
  logic [`ASC_CW-1:0] cnt_q, cnt_d;
  logic [`ASC_DW-1:0] rdSync;
  logic lastRead_q;
  logic cntDone;
  logic accept;
  logic selOn;
  logic driveWr;

  // Data pins cross from the memory's domain
  asc_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(data_lines_i),
    .syncOut(rdSync)
  );

  assign cntDone = (cnt_q == `ASC_CNT_ONE);
  assign accept = (state_q == asc_pkg::ASC_IDLE) && reqValid;
  assign selOn = (state_d == asc_pkg::ASC_RWAIT) || (state_d == asc_pkg::ASC_WPULSE);
  // Type comes from the request: lastRead_q still holds the previous one at the accepting edge
  assign driveWr = (accept && reqWrite) || (state_d == asc_pkg::ASC_WPULSE);

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q == `ASC_CNT_ZERO) ? cnt_q : cnt_q - `ASC_CNT_ONE;
    case (state_q)
      asc_pkg::ASC_IDLE: begin
        if (reqValid) begin
          // Address goes out a cycle before select asserts
          state_d = asc_pkg::ASC_RSETUP; // R5
        end
      end
      asc_pkg::ASC_RSETUP: begin
        state_d = lastRead_q ? asc_pkg::ASC_RWAIT : asc_pkg::ASC_WPULSE;
        cnt_d = lastRead_q ? RD_CNT : WR_CNT;
      end
      asc_pkg::ASC_RWAIT, asc_pkg::ASC_WPULSE: begin
        if (cntDone) begin
          state_d = asc_pkg::ASC_RECOVER;
          cnt_d = OFF_CNT;
        end
      end
      asc_pkg::ASC_RECOVER: begin
        // Gap lets the memory float before the next owner drives
        if (cntDone) begin
          state_d = asc_pkg::ASC_IDLE; // R11
        end
      end
      default: begin
        state_d = asc_pkg::ASC_IDLE;
        cnt_d = `ASC_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= asc_pkg::ASC_IDLE;
      cnt_q <= `ASC_CNT_ZERO;
      lastRead_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (accept) begin
        lastRead_q <= !reqWrite;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: address and data held through the whole cycle, zero hold is met
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      address_lines <= `ASC_ADDR_RST;
      data_lines_o <= `ASC_DATA_RST;
      data_lines_oe <= 1'b0;
      chip_select_low_n <= 1'b1;
      chip_select_high <= 1'b0;
      outEnable_n <= 1'b1;
      writeStrobe_n <= 1'b1;
    end else begin
      if (accept) begin
        address_lines <= reqAddr; // R13
        data_lines_o <= reqWdata; // R14
      end
      // Both selects switch together with opposite sense
      chip_select_low_n <= !selOn; // R2
      chip_select_high <= selOn; // R2
      // Write ends with strobe; select drops on the same edge, so neither outlasts the other
      writeStrobe_n <= !(state_d == asc_pkg::ASC_WPULSE); // R3 R12 R19
      // Output enable stays high in writes so the shorter pulse applies
      outEnable_n <= !(state_d == asc_pkg::ASC_RWAIT); // R17
      data_lines_oe <= driveWr; // R20
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reqReady <= 1'b1;
      rspValid <= 1'b0;
      rspRdata <= `ASC_DATA_RST;
    end else begin
      reqReady <= (state_d == asc_pkg::ASC_IDLE);
      rspValid <= (state_q == asc_pkg::ASC_RWAIT) && cntDone;
      if ((state_q == asc_pkg::ASC_RWAIT) && cntDone) begin
        rspRdata <= rdSync; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_start;
    $fell(writeStrobe_n);
  endsequence
  sequence s_wr_hold;
    !writeStrobe_n [*2];
  endsequence

  property p_sel_polarity;
    @(posedge ref_clk) disable iff (rst) chip_select_low_n == !chip_select_high;
  endproperty
  a_sel_polarity: assert property (p_sel_polarity) else $error("Selects disagree"); // R2

  property p_read_no_strobe;
    @(posedge ref_clk) disable iff (rst) !outEnable_n |-> writeStrobe_n;
  endproperty
  a_read_no_strobe: assert property (p_read_no_strobe) else $error("Strobe low in read"); // R3

  property p_wr_pulse;
    @(posedge ref_clk) disable iff (rst) s_wr_start |-> s_wr_hold;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("Write pulse too short"); // R12

  property p_wr_addr_stable;
    @(posedge ref_clk) disable iff (rst) !writeStrobe_n |-> $stable(address_lines);
  endproperty
  a_wr_addr_stable: assert property (p_wr_addr_stable) else $error("Address moved in write"); // R13

  property p_wr_data_driven;
    @(posedge ref_clk) disable iff (rst) !writeStrobe_n |-> data_lines_oe && $stable(data_lines_o);
  endproperty
  a_wr_data_driven: assert property (p_wr_data_driven) else $error("Write data not held"); // R14

  property p_wr_sel;
    @(posedge ref_clk) disable iff (rst) !writeStrobe_n |-> !chip_select_low_n && outEnable_n;
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("Select or enable wrong in write"); // R17

  property p_read_addr_first;
    @(posedge ref_clk) disable iff (rst) $fell(chip_select_low_n) |-> $stable(address_lines);
  endproperty
  a_read_addr_first: assert property (p_read_addr_first) else $error("Address changed with select"); // R5

  property p_rsp_time;
    @(posedge ref_clk) disable iff (rst) $fell(outEnable_n) |-> ##[2:12] rspValid;
  endproperty
  a_rsp_time: assert property (p_rsp_time) else $error("Read answer late"); // R21

  property p_no_contention;
    @(posedge ref_clk) disable iff (rst) data_lines_oe |-> outEnable_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("Bus contention"); // R11

  property p_read_no_drive;
    @(posedge ref_clk) disable iff (rst) lastRead_q |-> !data_lines_oe;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("Controller drives in read"); // R20
endmodule : asc_ctrl

/* bench/asc_sram_model.sv */
`timescale 1ns/1ns
`include "asc_defs.svh"
module asc_sram_model (
  // Pins from the controller
  input wire logic [`ASC_AW-1:0] address_lines,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic outEnable_n,
  input wire logic writeStrobe_n,
  input wire logic [`ASC_DW-1:0] dataIn,
  // Memory side of the shared lines
  output wire [`ASC_DW-1:0] dataOut,
  output wire dataDrive
);
  logic [`ASC_DW-1:0] mem [0:(1<<`ASC_AW)-1];
  wire [`ASC_AW-1:0] addrLate;
  wire [`ASC_DW-1:0] dataLate;
  wire selected = !chip_select_low_n && chip_select_high;
  wire writing = selected && !writeStrobe_n;
  wire wantDrive = selected && !outEnable_n && writeStrobe_n;
  // Off in 3 ns, on after 4 ns: release always wins, so no contention
  assign #(4, 3) dataDrive = wantDrive;
  // Old word lingers 5 ns after an address change, well inside access time
  assign #5 dataOut = mem[address_lines];
  // Late copies so the store sees values from before the closing edge
  assign #1 addrLate = address_lines;
  assign #1 dataLate = dataIn;
  always @(negedge writing) mem[addrLate] <= dataLate;
endmodule : asc_sram_model

/* bench/async_sram_cycle_timing_tb_top.sv */
`timescale 1ns/1ns
`include "asc_defs.svh"
module async_sram_cycle_timing_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0;
  logic [`ASC_AW-1:0] reqAddr = 15'h0000;
  logic [`ASC_DW-1:0] reqWdata = 9'h000;
  logic reqReady, rspValid, csLow_n, csHigh, oe_n, we_n, dOe, sramDrive;
  logic [`ASC_DW-1:0] rspRdata, dOut, sramOut;
  logic [`ASC_AW-1:0] addrPins;
  logic [`ASC_DW-1:0] refMem [logic [`ASC_AW-1:0]];
  int badCount = 0, nCompared = 0, cyc = 0;
  // Released lines show the inverse of the stored word, so a sample taken too early fails
  wire [`ASC_DW-1:0] busLevel = dOe ? dOut : (sramDrive ? sramOut : ~sramOut);
  always #5 ref_clk = ~ref_clk;
  asc_ctrl #(.GRADE_NS(15)) i_asc_ctrl (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .address_lines(addrPins), .chip_select_low_n(csLow_n), .chip_select_high(csHigh), .outEnable_n(oe_n),
    .writeStrobe_n(we_n), .data_lines_i(busLevel), .data_lines_o(dOut), .data_lines_oe(dOe));
  asc_sram_model i_asc_sram_model (.address_lines(addrPins), .chip_select_low_n(csLow_n),
    .chip_select_high(csHigh), .outEnable_n(oe_n), .writeStrobe_n(we_n), .dataIn(busLevel),
    .dataOut(sramOut), .dataDrive(sramDrive));
  //////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : giveVerdict
  // About a hundred transfers of at most nine cycles each, with ample margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      badCount++;
      $display("[ERR] %0t run took too long", $time);
      giveVerdict();
    end
  end
  task automatic check(input logic ok, input string what);
    nCompared++;
    if (ok !== 1'b1) begin
      badCount++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check
  function automatic logic [`ASC_DW-1:0] expWord(input logic [`ASC_AW-1:0] a);
    return refMem.exists(a) ? refMem[a] : 9'h000;
  endfunction : expWord
  // Held until the edge that takes it
  task automatic issue(input logic wr, input logic [`ASC_AW-1:0] a, input logic [`ASC_DW-1:0] d);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    // Ready only moves on a rising edge, so its value between edges is the one sampled
    @(negedge ref_clk);
    while (reqReady !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    reqValid <= 1'b0;
  endtask : issue
  task automatic doWrite(input logic [`ASC_AW-1:0] a, input logic [`ASC_DW-1:0] d);
    int lowCyc = 0;
    int n = 0;
    logic pinsOk = 1'b1;
    issue(1'b1, a, d);
    refMem[a] = d;
    do begin
      @(negedge ref_clk);
      n++;
      if (we_n === 1'b0) begin
        lowCyc++;
        if (!(addrPins === a && dOut === d && dOe === 1'b1 && csLow_n === 1'b0 && csHigh === 1'b1
            && oe_n === 1'b1)) pinsOk = 1'b0;
      end
    end while (reqReady !== 1'b1 && n < 20);
    check(lowCyc == 2, "write strobe width");
    check(pinsOk, "pins during write strobe");
    @(posedge ref_clk);
  endtask : doWrite
  task automatic doRead(input logic [`ASC_AW-1:0] a);
    int lat = 0;
    int onCyc = 0;
    logic weHigh = 1'b1;
    logic noDrive = 1'b1;
    logic [`ASC_DW-1:0] exp;
    exp = expWord(a);
    issue(1'b0, a, 9'($urandom));
    do begin
      @(negedge ref_clk);
      lat++;
      if (we_n !== 1'b1) weHigh = 1'b0;
      if (dOe !== 1'b0) noDrive = 1'b0;
      if (oe_n === 1'b0 && csLow_n === 1'b0 && csHigh === 1'b1 && addrPins === a) onCyc++;
    end while (rspValid !== 1'b1 && lat < 20);
    check(lat == 6, "read answer latency");
    check(onCyc == 4, "read select window");
    check(rspRdata === exp, "read data");
    check(weHigh, "write strobe low in read");
    check(noDrive, "controller drove data in read");
    @(negedge ref_clk);
    check(rspValid === 1'b0 && reqReady === 1'b1, "answer pulse or ready wrong");
    @(posedge ref_clk);
  endtask : doRead
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [`ASC_AW-1:0] cornerA [4] = '{15'h0000, 15'h7fff, 15'h5555, 15'h2aaa};
    logic [`ASC_DW-1:0] cornerD [4] = '{9'h1ff, 9'h000, 9'h0aa, 9'h155};
    logic [`ASC_AW-1:0] a;
    void'($urandom(32'ha3f91cbb));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(reqReady === 1'b1 && csLow_n === 1'b1 && csHigh === 1'b0 && dOe === 1'b0 && we_n === 1'b1,
      "idle pins after reset");
    @(posedge ref_clk);
    foreach (cornerA[i]) doWrite(cornerA[i], cornerD[i]);
    foreach (cornerA[i]) doRead(cornerA[i]);
    $display("test corners done");
    // Reset lands inside a read; the memory keeps its words
    issue(1'b0, 15'h7fff, 9'h000);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    check(csLow_n === 1'b1 && csHigh === 1'b0 && oe_n === 1'b1 && we_n === 1'b1 && dOe === 1'b0
      && reqReady === 1'b1 && rspValid === 1'b0, "idle pins in mid-run reset");
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    doRead(15'h7fff);
    $display("test mid reset done");
    doWrite(15'h0123, 9'h0f0);
    doWrite(15'h0123, 9'h10f);
    doRead(15'h0123);
    doRead(15'h0000);
    $display("test overwrite done");
    for (int i = 0; i < 80; i++) begin
      a = 15'($urandom_range(0, 15)) ^ 15'h4c30;
      if (!refMem.exists(a) || $urandom_range(0, 1) == 0) doWrite(a, 9'($urandom));
      else doRead(a);
    end
    $display("test random done");
    giveVerdict();
  end
endmodule : async_sram_cycle_timing_tb_top
